// >>> verilog/slc_pkg.sv
// Purpose: shared constants for the subscriber linefeed control block
// Assumes: 8-bit register port, 100 MHz clock
// Notes: register offsets, field layouts, reset values, state codes
package slc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_LINE_STATE = 8'h40;
  localparam logic [7:0] OFF_LOOP_CURRENT_LIMIT = 8'h47;
  localparam logic [7:0] OFF_VOC = 8'h48;
  localparam logic [7:0] OFF_VCM = 8'h49;
  localparam logic [7:0] OFF_LOOP_V = 8'h4E;
  localparam logic [7:0] OFF_LOOP_I = 8'h4F;
  localparam logic [7:0] OFF_ALARM = 8'h50;
  // ==========================================================
  // field widths and reset values
  localparam int LOOP_CURRENT_LIMIT_W = 3;
  localparam int VOLT_W = 6;
  localparam logic [2:0] LOOP_CURRENT_LIMIT_RST = 3'h0;
  localparam logic [5:0] VOC_RST = 6'h20;
  localparam logic [5:0] VCM_RST = 6'h02;
  localparam int AUTO_OPEN_ENABLE_BIT = 3;
  localparam int LS_W = 3;
  // ==========================================================
  // line states
  typedef enum logic [2:0] {
    LS_OPEN = 3'h0,
    LS_FWD_ACT = 3'h1,
    LS_FWD_OHT = 3'h2,
    LS_TIP_OPEN = 3'h3,
    LS_RINGING = 3'h4,
    LS_REV_ACT = 3'h5,
    LS_REV_OHT = 3'h6,
    LS_RING_OPEN = 3'h7
  } slc_state_e;
  // ==========================================================
  // timing: converter sample interval 1250 us at 800 Hz
  localparam int SAMPLE_US = 1250;
  localparam int CLK_MHZ = 100;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
endpackage

// >>> verilog/slc_sample_mem.sv
// Purpose: small register file holding the latest loop samples
// Assumes: synchronous write, registered read
// Notes: two 8-bit entries, voltage and current
`timescale 1ns/1ps
module slc_sample_mem (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_v,
  input wire logic [7:0] wr_i,
  // read side
  input wire logic rd_sel,
  output logic [7:0] rd_data_q
);
  logic [7:0] mem_q [0:1];
  always_ff @(posedge clock) begin
    if (rst) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else if (wr_en) begin
      mem_q[0] <= wr_v;
      mem_q[1] <= wr_i;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= mem_q[rd_sel];
    end
  end
endmodule // slc_sample_mem

// >>> verilog/slc_linefeed.sv
// Purpose: digital control of a telephone line driver
// Assumes: synchronous 8-bit register port, converter results as inputs
// Notes: line state decides driver enables and audio path enable
`timescale 1ns/1ps
module slc_linefeed (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // converter and power monitor
  input wire logic adc_valid,
  input wire logic [7:0] adc_loop_v,
  input wire logic [7:0] adc_loop_i,
  input wire logic power_alarm,
  input wire logic alarm_irq_enable,
  // line drive controls
  output logic tip_drive_en_q,
  output logic ring_drive_en_q,
  output logic audio_en_q,
  output logic ringing_en_q,
  output logic reverse_pol_q,
  output logic alarm_irq_q,
  output logic [2:0] loop_current_limit_q,
  output logic [5:0] open_circuit_voltage_q,
  output logic [5:0] common_mode_offset_q
);
  // ==========================================================
  // registers
  slc_pkg::slc_state_e line_state_select_q;
  logic auto_open_enable_q;
  logic alarm_flag_q;
  logic [7:0] rdata_d;
  logic [7:0] mem_rdata;
  logic mem_sel_q;
  logic mem_rd_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // line state register, auto-open on alarm
  always_ff @(posedge clock) begin
    if (rst) begin
      line_state_select_q <= slc_pkg::LS_OPEN;
      auto_open_enable_q <= 1'b0;
    end else if (power_alarm && auto_open_enable_q) begin
      line_state_select_q <= slc_pkg::LS_OPEN;
    end else if (reg_wr && hit(reg_addr, slc_pkg::OFF_LINE_STATE)) begin
      line_state_select_q <= slc_pkg::slc_state_e'(
        reg_wdata[slc_pkg::LS_W-1:0]);
      auto_open_enable_q <= reg_wdata[slc_pkg::AUTO_OPEN_ENABLE_BIT];
    end
  end

  // feed configuration; codes carried linearly to the analog loop
  always_ff @(posedge clock) begin
    if (rst) begin
      loop_current_limit_q <= slc_pkg::LOOP_CURRENT_LIMIT_RST;
      open_circuit_voltage_q <= slc_pkg::VOC_RST;
      common_mode_offset_q <= slc_pkg::VCM_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, slc_pkg::OFF_LOOP_CURRENT_LIMIT)) begin
        loop_current_limit_q <= reg_wdata[slc_pkg::LOOP_CURRENT_LIMIT_W-1:0];
      end else if (hit(reg_addr, slc_pkg::OFF_VOC)) begin
        open_circuit_voltage_q <= reg_wdata[slc_pkg::VOLT_W-1:0];
      end else if (hit(reg_addr, slc_pkg::OFF_VCM)) begin
        common_mode_offset_q <= reg_wdata[slc_pkg::VOLT_W-1:0];
      end
    end
  end

  // sticky alarm flag; set wins over clear-on-write
  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_flag_q <= 1'b0;
    end else if (power_alarm) begin
      alarm_flag_q <= 1'b1;
    end else if (reg_wr && hit(reg_addr, slc_pkg::OFF_ALARM) &&
                 reg_wdata[0]) begin
      alarm_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_irq_q <= 1'b0;
    end else begin
      alarm_irq_q <= alarm_flag_q && alarm_irq_enable;
    end
  end

  // ==========================================================
  // state decode to drivers
  always_ff @(posedge clock) begin
    if (rst) begin
      tip_drive_en_q <= 1'b0;
      ring_drive_en_q <= 1'b0;
      audio_en_q <= 1'b0;
      ringing_en_q <= 1'b0;
      reverse_pol_q <= 1'b0;
    end else begin
      tip_drive_en_q <= 1'b1;
      ring_drive_en_q <= 1'b1;
      audio_en_q <= 1'b0;
      ringing_en_q <= 1'b0;
      reverse_pol_q <= 1'b0;
      case (line_state_select_q)
        slc_pkg::LS_OPEN: begin
          tip_drive_en_q <= 1'b0;
          ring_drive_en_q <= 1'b0;
        end
        slc_pkg::LS_FWD_OHT: begin
          audio_en_q <= 1'b1;
        end
        slc_pkg::LS_TIP_OPEN: begin
          tip_drive_en_q <= 1'b0;
        end
        slc_pkg::LS_RINGING: begin
          ringing_en_q <= 1'b1;
        end
        slc_pkg::LS_REV_ACT: begin
          reverse_pol_q <= 1'b1;
        end
        slc_pkg::LS_REV_OHT: begin
          reverse_pol_q <= 1'b1;
          audio_en_q <= 1'b1;
        end
        slc_pkg::LS_RING_OPEN: begin
          ring_drive_en_q <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // latest loop samples, captured on each converter strobe
  slc_sample_mem u_mem (
    .clock(clock),
    .rst(rst),
    .wr_en(adc_valid),
    .wr_v(adc_loop_v),
    .wr_i(adc_loop_i),
    .rd_sel(hit(reg_addr, slc_pkg::OFF_LOOP_I)),
    .rd_data_q(mem_rdata)
  );

  // ==========================================================
  // read path
  always_comb begin
    rdata_d = 8'h00;
    if (hit(reg_addr, slc_pkg::OFF_LINE_STATE)) begin
      rdata_d = {4'h0, auto_open_enable_q, line_state_select_q};
    end else if (hit(reg_addr, slc_pkg::OFF_LOOP_CURRENT_LIMIT)) begin
      rdata_d = {5'h00, loop_current_limit_q};
    end else if (hit(reg_addr, slc_pkg::OFF_VOC)) begin
      rdata_d = {2'h0, open_circuit_voltage_q};
    end else if (hit(reg_addr, slc_pkg::OFF_VCM)) begin
      rdata_d = {2'h0, common_mode_offset_q};
    end else if (hit(reg_addr, slc_pkg::OFF_ALARM)) begin
      rdata_d = {7'h00, alarm_flag_q};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mem_sel_q <= 1'b0;
      mem_rd_q <= 1'b0;
    end else begin
      mem_sel_q <= hit(reg_addr, slc_pkg::OFF_LOOP_V) ||
                   hit(reg_addr, slc_pkg::OFF_LOOP_I);
      mem_rd_q <= reg_rd;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else if (mem_rd_q && mem_sel_q) begin
      reg_rdata_q <= mem_rdata;
    end
  end

  // ==========================================================
  // assertions
  property p_open_drivers;
    @(posedge clock) disable iff (rst)
    line_state_select_q == slc_pkg::LS_OPEN |=>
      !tip_drive_en_q && !ring_drive_en_q;
  endproperty
  a_open_drivers: assert property (p_open_drivers)
    else $error("drivers on in open state");

  property p_auto_open;
    @(posedge clock) disable iff (rst)
    power_alarm && auto_open_enable_q |=>
      line_state_select_q == slc_pkg::LS_OPEN ##1 !tip_drive_en_q;
  endproperty
  a_auto_open: assert property (p_auto_open)
    else $error("alarm did not force open");

  property p_no_auto_open;
    @(posedge clock) disable iff (rst)
    power_alarm && !auto_open_enable_q && !reg_wr |=>
      $stable(line_state_select_q);
  endproperty
  a_no_auto_open: assert property (p_no_auto_open)
    else $error("state changed without auto-open");

  property p_alarm_flag;
    @(posedge clock) disable iff (rst)
    power_alarm |=> alarm_flag_q;
  endproperty
  a_alarm_flag: assert property (p_alarm_flag)
    else $error("alarm flag not set");

  property p_active_audio;
    @(posedge clock) disable iff (rst)
    line_state_select_q == slc_pkg::LS_FWD_ACT |=>
      !audio_en_q && tip_drive_en_q && ring_drive_en_q;
  endproperty
  a_active_audio: assert property (p_active_audio)
    else $error("active state drive wrong");

  property p_oht_audio;
    @(posedge clock) disable iff (rst)
    line_state_select_q == slc_pkg::LS_REV_OHT |=>
      audio_en_q && reverse_pol_q;
  endproperty
  a_oht_audio: assert property (p_oht_audio)
    else $error("on-hook transmission audio off");

  property p_tip_open;
    @(posedge clock) disable iff (rst)
    line_state_select_q == slc_pkg::LS_TIP_OPEN |=>
      !tip_drive_en_q && ring_drive_en_q;
  endproperty
  a_tip_open: assert property (p_tip_open)
    else $error("tip open drive wrong");

  property p_ring_open;
    @(posedge clock) disable iff (rst)
    line_state_select_q == slc_pkg::LS_RING_OPEN |=>
      tip_drive_en_q && !ring_drive_en_q;
  endproperty
  a_ring_open: assert property (p_ring_open)
    else $error("ring open drive wrong");

  property p_ringing;
    @(posedge clock) disable iff (rst)
    line_state_select_q == slc_pkg::LS_RINGING |=> ringing_en_q;
  endproperty
  a_ringing: assert property (p_ringing)
    else $error("ringing not applied");

  property p_loop_current_limit_write;
    @(posedge clock) disable iff (rst)
    reg_wr && reg_addr == slc_pkg::OFF_LOOP_CURRENT_LIMIT |=>
      loop_current_limit_q == $past(reg_wdata[2:0]);
  endproperty
  a_loop_current_limit_write: assert property (p_loop_current_limit_write)
    else $error("current limit not stored");
endmodule // slc_linefeed

// >>> verification/slc_line_model.sv
// Purpose: far-side model of the subscriber line and its sense path
// Assumes: drives its sense outputs at the falling clock edge; power_alarm is combinational from alarm_cmd and the drivers
// Notes: power alarm only appears while a driver is on
`timescale 1ns/1ps
module slc_line_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // drive state from the block
  input wire logic tip_drive_en_q,
  input wire logic ring_drive_en_q,
  input wire logic reverse_pol_q,
  // fault injection from the bench
  input wire logic alarm_cmd,
  // sense results
  output logic adc_valid,
  output logic [7:0] adc_loop_v,
  output logic [7:0] adc_loop_i,
  output logic power_alarm
);
  // ==========================================================
  // periodic sense samples
  logic [3:0] tick_q = 4'h0;
  logic valid_q = 1'b0;
  logic [7:0] v_q = 8'h00;
  logic [7:0] i_q = 8'h00;
  logic drv;
  assign drv = tip_drive_en_q | ring_drive_en_q;
  always @(negedge clock) begin
    tick_q <= rst ? 4'h0 : tick_q + 4'h1;
    valid_q <= (tick_q == 4'hF) && !rst;
    v_q <= {reverse_pol_q, drv ? {3'h1, tick_q} : 7'h00};
    i_q <= {reverse_pol_q, drv ? {3'h0, ~tick_q} : 7'h00};
  end
  assign adc_valid = valid_q;
  assign adc_loop_v = v_q;
  assign adc_loop_i = i_q;
  // ==========================================================
  // overheating needs current in a transistor
  assign power_alarm = alarm_cmd & drv;
endmodule // slc_line_model

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the linefeed control block
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic alarm_irq_enable = 1'b0;
  logic alarm_cmd = 1'b0;
  logic [7:0] reg_rdata_q, adc_loop_v, adc_loop_i, rd, d;
  logic adc_valid, power_alarm, alarm_irq_q, ringing_en_q, reverse_pol_q;
  logic tip_drive_en_q, ring_drive_en_q, audio_en_q;
  logic [2:0] loop_current_limit_q;
  logic [5:0] open_circuit_voltage_q, common_mode_offset_q;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  // ==========================================================
  // design and far side
  slc_linefeed i_slc_linefeed (.clock(clock), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .adc_valid(adc_valid),
    .adc_loop_v(adc_loop_v), .adc_loop_i(adc_loop_i),
    .power_alarm(power_alarm), .alarm_irq_enable(alarm_irq_enable),
    .tip_drive_en_q(tip_drive_en_q), .ring_drive_en_q(ring_drive_en_q),
    .audio_en_q(audio_en_q), .ringing_en_q(ringing_en_q),
    .reverse_pol_q(reverse_pol_q), .alarm_irq_q(alarm_irq_q),
    .loop_current_limit_q(loop_current_limit_q),
    .open_circuit_voltage_q(open_circuit_voltage_q),
    .common_mode_offset_q(common_mode_offset_q));
  slc_line_model i_slc_line_model (.clock(clock), .rst(rst),
    .tip_drive_en_q(tip_drive_en_q), .ring_drive_en_q(ring_drive_en_q),
    .reverse_pol_q(reverse_pol_q), .alarm_cmd(alarm_cmd),
    .adc_valid(adc_valid), .adc_loop_v(adc_loop_v),
    .adc_loop_i(adc_loop_i), .power_alarm(power_alarm));
  // ==========================================================
  // helpers
  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    v = reg_rdata_q;
  endtask
  // expected {tip, ring, audio, ringing, reverse} and the bits that matter
  function automatic logic [4:0] exp_drv(input logic [2:0] s);
    case (s)
      3'h1: return 5'h18;
      3'h2: return 5'h1C;
      3'h3: return 5'h08;
      3'h4: return 5'h02;
      3'h5: return 5'h19;
      3'h6: return 5'h1D;
      3'h7: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction
  function automatic logic [4:0] exp_mask(input logic [2:0] s);
    return (s == 3'h3 || s == 3'h7) ? 5'h1A : (s == 3'h4) ? 5'h02 : 5'h1F;
  endfunction
  // expected upper nibble of a loop sample: sign, then drive marker
  function automatic logic [7:0] exp_smp(input logic [2:0] s,
                                         input logic v);
    return {(s == 3'h5 || s == 3'h6), (v && s != 3'h0) ? 3'h1 : 3'h0,
      4'h0};
  endfunction
  task automatic check_drv(input logic [2:0] s);
    logic [4:0] o;
    o = {tip_drive_en_q, ring_drive_en_q, audio_en_q, ringing_en_q,
      reverse_pol_q};
    check({3'h0, o & exp_mask(s)}, {3'h0, exp_drv(s) & exp_mask(s)});
  endtask
  task automatic alarm_pulse;
    @(negedge clock);
    alarm_cmd = 1'b1;
    @(negedge clock);
    alarm_cmd = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h2757_2c32));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    rd_reg(8'h40, rd);
    check(rd, 8'h00);
    check_drv(3'h0);
    rd_reg(slc_pkg::OFF_LOOP_CURRENT_LIMIT, rd);
    check(rd & 8'h07, 8'h00);
    rd_reg(slc_pkg::OFF_VOC, rd);
    check(rd & 8'h3F, 8'(480 / 15));
    rd_reg(slc_pkg::OFF_VCM, rd);
    check(rd & 8'h3F, 8'(30 / 15));
    wr(8'h41, 8'hA5);
    rd_reg(8'h41, rd);
    check(rd, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      wr(slc_pkg::OFF_LOOP_CURRENT_LIMIT, d);
      wr(slc_pkg::OFF_VOC, ~d);
      wr(slc_pkg::OFF_VCM, d);
      check({5'h0, loop_current_limit_q}, d & 8'h07);
      check({2'h0, open_circuit_voltage_q}, ~d & 8'h3F);
      check({2'h0, common_mode_offset_q}, d & 8'h3F);
      rd_reg(slc_pkg::OFF_VOC, rd);
      check(rd & 8'h3F, ~d & 8'h3F);
    end
    // feed settings go in before any active state
    wr(slc_pkg::OFF_LOOP_CURRENT_LIMIT, 8'h07);
    wr(slc_pkg::OFF_VOC, 8'h3F);
    wr(slc_pkg::OFF_VCM, 8'h02);
    check({5'h0, loop_current_limit_q}, 8'((41 - 20) / 3));
    check({2'h0, open_circuit_voltage_q}, 8'(945 / 15));
    for (int s = 7; s >= 0; s--) begin
      wr(8'h40, {4'($urandom) & 4'h0, 1'b0, 3'(s)});
      rd_reg(8'h40, rd);
      check(rd & 8'h07, 8'(s));
      check_drv(3'(s));
      repeat (20) @(negedge clock);
      rd_reg(slc_pkg::OFF_LOOP_V, rd);
      check(rd & 8'hF0, exp_smp(3'(s), 1'b1));
      rd_reg(slc_pkg::OFF_LOOP_I, rd);
      check(rd & 8'hF0, exp_smp(3'(s), 1'b0));
    end
    alarm_irq_enable = 1'b1;
    wr(8'h40, 8'h09);
    alarm_pulse;
    check_drv(3'h0);
    check({7'h0, alarm_irq_q}, 8'h01);
    rd_reg(8'h40, rd);
    check(rd & 8'h0F, 8'h08);
    rd_reg(slc_pkg::OFF_ALARM, rd);
    check(rd & 8'h01, 8'h01);
    wr(slc_pkg::OFF_ALARM, 8'h01);
    check({7'h0, alarm_irq_q}, 8'h00);
    alarm_irq_enable = 1'b0;
    wr(8'h40, 8'h05);
    alarm_pulse;
    check_drv(3'h5);
    check({7'h0, alarm_irq_q}, 8'h00);
    rd_reg(slc_pkg::OFF_ALARM, rd);
    check(rd & 8'h01, 8'h01);
    test_done;
  end
endmodule // tb_top
